// File: pwu_core_model.sv
`default_nettype none
module pwu_core_model (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // handshake with the unit
  input  wire logic halt_req,
  input  wire logic slow,
  output logic      core_quiesced
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_r;
  // a slow core still has bus cycles to drain before it reports quiet
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 4'h0;
    end else if (!halt_req) begin
      cnt_r <= 4'h0;
    end else if (cnt_r != 4'hf) begin
      cnt_r <= cnt_r + 4'h1;
    end
  end
  assign core_quiesced = halt_req && (cnt_r >= (slow ? 4'h9 : 4'h1));
endmodule // pwu_core_model
`default_nettype wire

// File: pwu_pkg.sv
`default_nettype none
package pwu_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_STATUS  = 8'h04;
  localparam logic [7:0] OFS_IRQ_EN  = 8'h08;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h0c;
  localparam logic [7:0] OFS_DOZE    = 8'h10;
  localparam logic [7:0] OFS_STBY    = 8'h14;
  localparam logic [7:0] OFS_SUSPEND_CTL_N    = 8'h18;
  localparam logic [7:0] OFS_HK      = 8'h1c;
  localparam logic [7:0] OFS_PERIPH  = 8'h20;
  localparam logic [7:0] OFS_MOD     = 8'h24;
  localparam logic [7:0] OFS_PSTATE  = 8'h28;
  // control register fields
  localparam int CTRL_STATE_LSB = 0;
  localparam int CTRL_SW_SUSPEND_CTL_N   = 2;
  localparam int CTRL_MGMT_EXIT = 3;
  localparam int CTRL_PLANE_LSB = 4;
  // status bit positions
  localparam int ST_DOZE_EXP   = 0;
  localparam int ST_STBY_EXP   = 1;
  localparam int ST_SUSPEND_CTL_N_EXP   = 2;
  localparam int ST_ACT_LOW    = 3;
  localparam int ST_HK_EXP     = 4;
  localparam int ST_PERIPH_EXP = 5;
  localparam int ST_WAKE       = 6;
  localparam int ST_HW_SUSPEND_CTL_N    = 7;
  localparam int ST_W          = 8;
  // reset values
  localparam logic [31:0] RST_DOZE   = 32'h0000_1000;
  localparam logic [31:0] RST_STBY   = 32'h0001_0000;
  localparam logic [31:0] RST_SUSPEND_CTL_N   = 32'h0010_0000;
  localparam logic [31:0] RST_HK     = 32'h0000_0100;
  localparam logic [31:0] RST_PERIPH = 32'h0001_0000;
  localparam logic [11:0] RST_MOD    = 12'h000;
  localparam logic [3:0]  RST_PLANE  = 4'h0;

  typedef enum logic [2:0] {
    PS_ON      = 3'b000,
    PS_DOZE    = 3'b001,
    PS_STBY    = 3'b010,
    PS_WAIT    = 3'b011,
    PS_SUSPEND = 3'b100
  } pwu_state_e;

  // pin level inputs, all asynchronous to pclk
  typedef struct packed {
    logic       sys_act;
    logic       hk_act;
    logic [2:0] periph_act;  // disk, serial, parallel
    logic       wake_rtc;
    logic       wake_irq;
    logic       wake_dma;
    logic       hw_suspend_ctl_n_req;
  } pwu_pins_s;

  typedef struct packed {
    pwu_pins_s   sync1;
    pwu_pins_s   sync2;
    pwu_state_e  state;
    logic        mgmt_state;
    logic        irq_q;
    logic [ST_W-1:0] status;
    logic [ST_W-1:0] irq_en;
    logic [31:0] rl_doze;
    logic [31:0] rl_stby;
    logic [31:0] rl_suspend_ctl_n;
    logic [31:0] rl_hk;
    logic [31:0] rl_periph;
    logic [31:0] c_doze;
    logic [31:0] c_stby;
    logic [31:0] c_suspend_ctl_n;
    logic [31:0] c_hk;
    logic [31:0] c_periph;
    logic [11:0] mod;
    logic [3:0]  phase;
    logic [3:0]  plane_off;
    logic [31:0] rdata;
    logic        suspend_ctl_n;
  } pwu_regs_s;
endpackage
`default_nettype wire

// File: pwu_power_unit.sv
`default_nettype none
// What this block does
// - Three inactivity timers count doze, stand-by and suspend periods.
// - An expiring inactivity timer can raise the management interrupt.
// - Activity seen in a reduced power state can raise the management interrupt.
// - Reduced states are doze, stand-by and suspend, in rising order of saving.
// - House-keeping activity runs its own timer and does not wake doze or stand-by.
// - Peripheral activity reloads a peripheral timer that reports inactivity.
// - The suspend control output is duty-modulated in full-on, doze and stand-by, and held low while suspending or suspended.
// - Power control outputs can switch off separate board power planes.
// - Suspend is entered on a hardware pin request or a software request.
// - Suspend waits until the core reports its instruction and bus cycles done.
// - In suspend the internal clocks stop while all state is held.
// - On leaving suspend the clocks restart with no reset, so execution continues.
// - The management interrupt puts the core into an isolated management state.
// - The peripheral timer is independent and watches disk, serial and parallel ports.
// - Real-time clock, interrupt and DMA events wake the unit from suspend.
module pwu_power_unit (
  // apb
  input  wire logic            pclk,
  input  wire logic            presetn,
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [7:0]      paddr,
  input  wire logic [31:0]     pwdata,
  output logic [31:0]          prdata,
  output logic                 pready,
  output logic                 pslverr,
  // activity and wake pins
  input  wire pwu_pkg::pwu_pins_s pins,
  // core side
  input  wire logic            core_quiesced,
  output logic                 mgmt_interrupt,
  output logic                 isolated_mgmt_state,
  output logic                 clock_halt_request,
  output logic                 clocks_stopped,
  // board side
  output logic                 suspend_ctl_n,
  output logic [3:0]           plane_off
);
  import pwu_pkg::*;

  pwu_regs_s r_r;
  pwu_regs_s r_nxt;

  function automatic logic [31:0] tick(input logic [31:0] c);
    tick = (c == 32'h0) ? 32'h0 : c - 32'h1;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a <= OFS_PSTATE) && (a[1:0] == 2'b00);
  endfunction

  logic        wr;
  logic        setup;
  logic [ST_W-1:0] set_ev;
  logic [ST_W-1:0] clr_ev;
  logic        wake_ev;
  logic [3:0]  duty;

  assign wr    = psel && penable && pwrite && mapped(paddr);
  assign setup = psel && !penable;

  always_comb begin
    r_nxt = r_r;
    set_ev = '0;
    clr_ev = '0;
    duty = 4'h0;
    r_nxt.sync1 = pins;
    r_nxt.sync2 = r_r.sync1;
    wake_ev = r_r.sync2.wake_rtc | r_r.sync2.wake_irq | r_r.sync2.wake_dma;
    // timers; only the synchronised copies feed logic
    r_nxt.c_doze   = tick(r_r.c_doze);
    r_nxt.c_stby   = tick(r_r.c_stby);
    r_nxt.c_suspend_ctl_n   = tick(r_r.c_suspend_ctl_n);
    r_nxt.c_hk     = tick(r_r.c_hk);
    r_nxt.c_periph = tick(r_r.c_periph);
    if (r_r.c_doze == 32'h1) set_ev[ST_DOZE_EXP] = 1'b1;
    if (r_r.c_stby == 32'h1) set_ev[ST_STBY_EXP] = 1'b1;
    if (r_r.c_suspend_ctl_n == 32'h1) set_ev[ST_SUSPEND_CTL_N_EXP] = 1'b1;
    if (r_r.c_hk == 32'h1) set_ev[ST_HK_EXP] = 1'b1;
    if (r_r.c_periph == 32'h1) set_ev[ST_PERIPH_EXP] = 1'b1;
    if (r_r.sync2.sys_act) begin
      r_nxt.c_doze = r_r.rl_doze;
      r_nxt.c_stby = r_r.rl_stby;
      r_nxt.c_suspend_ctl_n = r_r.rl_suspend_ctl_n;
    end
    // house-keeping bursts restart only their own timer
    if (r_r.sync2.hk_act) r_nxt.c_hk = r_r.rl_hk;
    if (|r_r.sync2.periph_act) r_nxt.c_periph = r_r.rl_periph;
    if (r_r.sync2.sys_act && r_r.state != PS_ON) set_ev[ST_ACT_LOW] = 1'b1;
    if (wake_ev && r_r.state != PS_ON) set_ev[ST_WAKE] = 1'b1;
    if (r_r.sync2.hw_suspend_ctl_n_req && r_r.state != PS_SUSPEND) set_ev[ST_HW_SUSPEND_CTL_N] = 1'b1;

    // power state sequencing
    case (r_r.state)
      PS_ON, PS_DOZE, PS_STBY: begin
        if (r_r.sync2.hw_suspend_ctl_n_req) begin
          r_nxt.state = PS_WAIT;
        end else if (wr && paddr == OFS_CTRL && pwdata[CTRL_SW_SUSPEND_CTL_N]) begin
          r_nxt.state = PS_WAIT;
        end else if (wr && paddr == OFS_CTRL) begin
          case (pwdata[CTRL_STATE_LSB +: 2])
            2'b01:   r_nxt.state = PS_DOZE;
            2'b10:   r_nxt.state = PS_STBY;
            default: r_nxt.state = PS_ON;
          endcase
        end
      end
      PS_WAIT: begin
        // clocks stop only once the core has drained its pipeline and bus
        if (core_quiesced) r_nxt.state = PS_SUSPEND;
      end
      PS_SUSPEND: begin
        if (wake_ev || r_r.sync2.sys_act) r_nxt.state = PS_ON;
      end
      default: r_nxt.state = PS_ON;
    endcase

    // sticky status, set wins over clear
    if (wr && paddr == OFS_IRQ_CLR) clr_ev = pwdata[ST_W-1:0];
    r_nxt.status = (r_r.status & ~clr_ev) | set_ev;
    r_nxt.irq_q = |(r_nxt.status & r_r.irq_en);
    if (r_nxt.irq_q && !r_r.irq_q) begin
      r_nxt.mgmt_state = 1'b1;
    end else if (wr && paddr == OFS_CTRL && pwdata[CTRL_MGMT_EXIT]) begin
      r_nxt.mgmt_state = 1'b0;
    end

    // register writes
    if (wr) begin
      if (paddr == OFS_CTRL) begin
        r_nxt.plane_off = pwdata[CTRL_PLANE_LSB +: 4];
      end else if (paddr == OFS_IRQ_EN) begin
        r_nxt.irq_en = pwdata[ST_W-1:0];
      end else if (paddr == OFS_DOZE) begin
        r_nxt.rl_doze = pwdata;
      end else if (paddr == OFS_STBY) begin
        r_nxt.rl_stby = pwdata;
      end else if (paddr == OFS_SUSPEND_CTL_N) begin
        r_nxt.rl_suspend_ctl_n = pwdata;
      end else if (paddr == OFS_HK) begin
        r_nxt.rl_hk = pwdata;
      end else if (paddr == OFS_PERIPH) begin
        r_nxt.rl_periph = pwdata;
      end else if (paddr == OFS_MOD) begin
        r_nxt.mod = pwdata[11:0];
      end
    end

    // read data captured in the setup cycle so the access phase needs no wait
    if (setup) begin
      if (paddr == OFS_CTRL) begin
        r_nxt.rdata = {24'h0, r_r.plane_off, 4'h0};
      end else if (paddr == OFS_STATUS) begin
        r_nxt.rdata = {24'h0, r_r.status};
      end else if (paddr == OFS_IRQ_EN) begin
        r_nxt.rdata = {24'h0, r_r.irq_en};
      end else if (paddr == OFS_DOZE) begin
        r_nxt.rdata = r_r.rl_doze;
      end else if (paddr == OFS_STBY) begin
        r_nxt.rdata = r_r.rl_stby;
      end else if (paddr == OFS_SUSPEND_CTL_N) begin
        r_nxt.rdata = r_r.rl_suspend_ctl_n;
      end else if (paddr == OFS_HK) begin
        r_nxt.rdata = r_r.rl_hk;
      end else if (paddr == OFS_PERIPH) begin
        r_nxt.rdata = r_r.rl_periph;
      end else if (paddr == OFS_MOD) begin
        r_nxt.rdata = {20'h0, r_r.mod};
      end else if (paddr == OFS_PSTATE) begin
        r_nxt.rdata = {26'h0, (r_r.c_hk != 32'h0), r_r.mgmt_state, 1'b0, r_r.state};
      end else begin
        r_nxt.rdata = 32'h0;
      end
    end

    // duty modulation over a 16-cycle frame; low means the core is held
    r_nxt.phase = r_r.phase + 4'h1;
    case (r_r.state)
      PS_ON:   duty = r_r.mod[3:0];
      PS_DOZE: duty = r_r.mod[7:4];
      PS_STBY: duty = r_r.mod[11:8];
      default: duty = 4'hf;
    endcase
    if (r_r.state == PS_WAIT || r_r.state == PS_SUSPEND) begin
      r_nxt.suspend_ctl_n = 1'b0;
    end else begin
      r_nxt.suspend_ctl_n = !(r_r.phase < duty);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_r <= '{sync1: '0, sync2: '0, state: PS_ON, mgmt_state: 1'b0, irq_q: 1'b0,
               status: '0, irq_en: '0, rl_doze: RST_DOZE, rl_stby: RST_STBY,
               rl_suspend_ctl_n: RST_SUSPEND_CTL_N, rl_hk: RST_HK, rl_periph: RST_PERIPH,
               c_doze: RST_DOZE, c_stby: RST_STBY, c_suspend_ctl_n: RST_SUSPEND_CTL_N, c_hk: 32'h0,
               c_periph: RST_PERIPH, mod: RST_MOD, phase: 4'h0,
               plane_off: RST_PLANE, rdata: 32'h0, suspend_ctl_n: 1'b1};
    end else begin
      r_r <= r_nxt;
    end
  end

  assign prdata              = r_r.rdata;
  assign pready              = 1'b1;
  assign pslverr             = psel && penable && !mapped(paddr);
  assign mgmt_interrupt      = r_r.irq_q;
  assign isolated_mgmt_state = r_r.mgmt_state;
  assign clock_halt_request  = (r_r.state == PS_WAIT);
  // clock gate only; no state is reset, so the core resumes where it stopped
  assign clocks_stopped      = (r_r.state == PS_SUSPEND);
  assign suspend_ctl_n       = r_r.suspend_ctl_n;
  assign plane_off           = r_r.plane_off;

  property p_quiesce;
    @(posedge pclk) disable iff (!presetn)
      $rose(clocks_stopped) |-> $past(core_quiesced) && $past(clock_halt_request);
  endproperty
  a_quiesce: assert property (p_quiesce) else $error("suspend entered before core quiesced");

  property p_reload;
    @(posedge pclk) disable iff (!presetn)
      r_r.sync2.sys_act |=> r_r.c_doze == $past(r_r.rl_doze) && r_r.c_suspend_ctl_n == $past(r_r.rl_suspend_ctl_n);
  endproperty
  a_reload: assert property (p_reload) else $error("activity did not reload timers");

  property p_expire;
    @(posedge pclk) disable iff (!presetn)
      (r_r.c_doze == 32'h1) |=> r_r.status[ST_DOZE_EXP];
  endproperty
  a_expire: assert property (p_expire) else $error("doze expiry not recorded");

  property p_mgmt;
    @(posedge pclk) disable iff (!presetn)
      $rose(mgmt_interrupt) |-> isolated_mgmt_state;
  endproperty
  a_mgmt: assert property (p_mgmt) else $error("interrupt without management state");

  property p_hwsusp;
    @(posedge pclk) disable iff (!presetn)
      (r_r.sync2.hw_suspend_ctl_n_req && r_r.state == PS_ON) |=> ##[0:1] clock_halt_request;
  endproperty
  a_hwsusp: assert property (p_hwsusp) else $error("hardware suspend request ignored");

  property p_wake;
    @(posedge pclk) disable iff (!presetn)
      (clocks_stopped && r_r.sync2.wake_rtc) |=> !clocks_stopped && r_r.status[ST_WAKE];
  endproperty
  a_wake: assert property (p_wake) else $error("wake did not restart clocks");

  property p_hk;
    @(posedge pclk) disable iff (!presetn)
      (r_r.state == PS_DOZE && r_r.sync2.hk_act && !r_r.sync2.sys_act && !psel
       && !r_r.sync2.hw_suspend_ctl_n_req) |=> r_r.state == PS_DOZE && r_r.c_hk == $past(r_r.rl_hk);
  endproperty
  a_hk: assert property (p_hk) else $error("house-keeping burst changed state");

  property p_mod;
    @(posedge pclk) disable iff (!presetn)
      (r_r.state == PS_ON && r_r.mod[3:0] == 4'h0) [*2] |-> suspend_ctl_n;
  endproperty
  a_mod: assert property (p_mod) else $error("zero duty still held the core");

  property p_suspend_ctl_n_low;
    @(posedge pclk) disable iff (!presetn)
      clocks_stopped |-> !suspend_ctl_n && !clock_halt_request;
  endproperty
  a_suspend_ctl_n_low: assert property (p_suspend_ctl_n_low) else $error("suspend outputs inconsistent");

  property p_setwins;
    @(posedge pclk) disable iff (!presetn)
      (r_r.c_periph == 32'h1) |=> r_r.status[ST_PERIPH_EXP];
  endproperty
  a_setwins: assert property (p_setwins) else $error("peripheral expiry lost");

  property p_clr;
    @(posedge pclk) disable iff (!presetn)
      (wr && paddr == OFS_IRQ_CLR && pwdata[ST_DOZE_EXP] && r_r.c_doze != 32'h1)
      |=> !r_r.status[ST_DOZE_EXP];
  endproperty
  a_clr: assert property (p_clr) else $error("status clear lost");

  property p_plane;
    @(posedge pclk) disable iff (!presetn)
      (wr && paddr == OFS_CTRL) |=> plane_off == $past(pwdata[CTRL_PLANE_LSB +: 4]);
  endproperty
  a_plane: assert property (p_plane) else $error("plane control not written");

  // a stopped unit may only leave suspend on a wake source or activity
  property p_hold;
    @(posedge pclk) disable iff (!presetn)
      (clocks_stopped && !wake_ev && !r_r.sync2.sys_act) |=> clocks_stopped;
  endproperty
  a_hold: assert property (p_hold) else $error("suspend left without wake");

  property p_actlow;
    @(posedge pclk) disable iff (!presetn)
      (r_r.sync2.sys_act && r_r.state != PS_ON) |=> r_r.status[ST_ACT_LOW];
  endproperty
  a_actlow: assert property (p_actlow) else $error("low power activity not recorded");

  property p_periph_rl;
    @(posedge pclk) disable iff (!presetn)
      (|r_r.sync2.periph_act) |=> r_r.c_periph == $past(r_r.rl_periph);
  endproperty
  a_periph_rl: assert property (p_periph_rl) else $error("periph timer not reloaded");

  property p_wait_low;
    @(posedge pclk) disable iff (!presetn)
      (r_r.state == PS_WAIT) |=> !suspend_ctl_n;
  endproperty
  a_wait_low: assert property (p_wait_low) else $error("core not held while draining");

  property p_swsusp;
    @(posedge pclk) disable iff (!presetn)
      (r_r.state == PS_ON && wr && paddr == OFS_CTRL && pwdata[CTRL_SW_SUSPEND_CTL_N])
      |=> clock_halt_request;
  endproperty
  a_swsusp: assert property (p_swsusp) else $error("software suspend request ignored");

  property p_cov_suspend_ctl_n;
    @(posedge pclk) disable iff (!presetn) $rose(clocks_stopped);
  endproperty
  c_cov_suspend_ctl_n: cover property (p_cov_suspend_ctl_n);

  property p_cov_wake;
    @(posedge pclk) disable iff (!presetn) $fell(clocks_stopped);
  endproperty
  c_cov_wake: cover property (p_cov_wake);

  property p_cov_irq;
    @(posedge pclk) disable iff (!presetn) $rose(mgmt_interrupt);
  endproperty
  c_cov_irq: cover property (p_cov_irq);

  property p_cov_hk;
    @(posedge pclk) disable iff (!presetn) $rose(r_r.status[ST_HK_EXP]);
  endproperty
  c_cov_hk: cover property (p_cov_hk);

  property p_cov_hwsusp;
    @(posedge pclk) disable iff (!presetn) $rose(r_r.status[ST_HW_SUSPEND_CTL_N]);
  endproperty
  c_cov_hwsusp: cover property (p_cov_hwsusp);
endmodule // pwu_power_unit
`default_nettype wire

// File: tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pwu_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, quiet, slow;
  logic mirq, iso, halt, stopped, sctl_n, er;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  plane;
  pwu_pins_s   pins;
  int fail_count, num_checks, c;

  pwu_power_unit u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pins(pins), .core_quiesced(quiet), .mgmt_interrupt(mirq),
    .isolated_mgmt_state(iso), .clock_halt_request(halt), .clocks_stopped(stopped),
    .suspend_ctl_n(sctl_n), .plane_off(plane));
  pwu_core_model u_core (.pclk(pclk), .presetn(presetn), .halt_req(halt), .slow(slow),
    .core_quiesced(quiet));

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 50) begin
      fail_count++;
      tally_and_finish();
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd & m, e);
  endtask

  function automatic logic pick(input int id);
    case (id)
      0: return mirq;
      1: return halt;
      default: return stopped;
    endcase
  endfunction

  // status bits are polled over the bus so a missing event ends the run
  task automatic wait_on(input int id, input logic v, input int bound);
    int n;
    for (n = 0; n < bound; n++) begin
      if (id < 3) begin
        @(posedge pclk);
        if (pick(id) === v) break;
      end else begin
        apb(1'b0, OFS_STATUS, 32'h0);
        if (rd[id-3] === v) break;
      end
    end
    if (n == bound) begin
      fail_count++;
      tally_and_finish();
    end
  endtask

  initial begin
    {psel, penable, pwrite, slow, presetn} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pins = '0;
    pins.sys_act = 1'b1;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    chk({mirq, iso, halt, stopped, sctl_n, plane}, 32'h10);
    rdc(OFS_PSTATE, 32'h37, 32'h0);
    rdc(8'h2c, 32'hffffffff, 32'h0);
    chk(er, 1'b1);
    wr(OFS_DOZE, 32'd20);
    wr(OFS_STBY, 32'd60);
    wr(OFS_SUSPEND_CTL_N, 32'd400);
    wr(OFS_HK, 32'd30);
    wr(OFS_PERIPH, 32'd30);
    rdc(OFS_DOZE, 32'hffffffff, 32'd20);
    $display("test regs done");
    // doze then stand-by expiry, each taken as a management interrupt
    for (int k = 0; k < 2; k++) begin
      wr(OFS_IRQ_EN, 32'h1 << k);
      pins.sys_act <= 1'b0;
      repeat (10) @(posedge pclk);
      chk(mirq, 1'b0);
      wait_on(0, 1'b1, 200);
      chk(iso, 1'b1);
      rdc(OFS_STATUS, 32'h3, k ? 32'h3 : 32'h1);
      pins.sys_act <= 1'b1;
      repeat (4) @(posedge pclk);
      wr(OFS_IRQ_CLR, 32'hff);
      rdc(OFS_STATUS, 32'h3, 32'h0);
      chk(mirq, 1'b0);
      wr(OFS_CTRL, 32'h8);
      @(posedge pclk);
      chk(iso, 1'b0);
    end
    $display("test timers done");
    pins.sys_act <= 1'b0;
    repeat (4) @(posedge pclk);
    wr(OFS_IRQ_CLR, 32'hff);
    wr(OFS_IRQ_EN, 32'h8);
    for (int s = 1; s < 3; s++) begin
      wr(OFS_CTRL, s);
      rdc(OFS_PSTATE, 32'h7, s);
    end
    pins.sys_act <= 1'b1;
    wait_on(0, 1'b1, 20);
    rdc(OFS_STATUS, 32'h8, 32'h8);
    wr(OFS_CTRL, 32'h8);
    wr(OFS_IRQ_EN, 32'h0);
    $display("test activity done");
    // activity off so that only the house-keeping burst is seen in doze
    pins.sys_act <= 1'b0;
    wr(OFS_CTRL, 32'h1);
    wr(OFS_IRQ_CLR, 32'hff);
    pins.hk_act <= 1'b1;
    repeat (4) @(posedge pclk);
    pins.hk_act <= 1'b0;
    wait_on(3 + ST_HK_EXP, 1'b1, 40);
    rdc(OFS_PSTATE, 32'h7, 32'h1);
    wr(OFS_CTRL, 32'h0);
    for (int i = 0; i < 3; i++) begin
      pins.periph_act[i] <= 1'b1;
      repeat (40) @(posedge pclk);
      wr(OFS_IRQ_CLR, 32'hff);
      rdc(OFS_STATUS, 32'h20, 32'h0);
      pins.periph_act[i] <= 1'b0;
      wait_on(3 + ST_PERIPH_EXP, 1'b1, 40);
    end
    $display("test periph done");
    // zero duty in full-on, then half duty in full-on, doze and stand-by
    for (int d = 0; d < 4; d++) begin
      wr(OFS_CTRL, (d > 0) ? d - 1 : 0);
      wr(OFS_MOD, (d > 0) ? 32'h8 << (4 * (d - 1)) : 32'h0);
      @(posedge pclk);
      c = 0;
      repeat (32) begin
        @(posedge pclk);
        c += (sctl_n === 1'b0);
      end
      chk(c, (d > 0) ? 32'd16 : 32'd0);
    end
    wr(OFS_CTRL, 32'ha0);
    @(posedge pclk);
    chk(plane, 4'ha);
    rdc(OFS_CTRL, 32'hf0, 32'ha0);
    $display("test board done");
    pins.sys_act <= 1'b0;
    for (int k = 0; k < 3; k++) begin
      slow <= k[0];
      wr(OFS_IRQ_CLR, 32'hff);
      if (k[0]) pins.hw_suspend_ctl_n_req <= 1'b1;
      else wr(OFS_CTRL, 32'h4);
      wait_on(1, 1'b1, 20);
      // the held level is registered one edge after the halt request
      @(posedge pclk);
      chk(sctl_n, 1'b0);
      wait_on(2, 1'b1, 30);
      pins.hw_suspend_ctl_n_req <= 1'b0;
      repeat (4) @(posedge pclk);
      chk(stopped, 1'b1);
      pins[3-k] <= 1'b1;
      wait_on(2, 1'b0, 20);
      pins[3-k] <= 1'b0;
      rdc(OFS_PSTATE, 32'h7, 32'h0);
      rdc(OFS_STATUS, 32'hc0, k[0] ? 32'hc0 : 32'h40);
    end
    $display("test suspend done");
    tally_and_finish();
  end
endmodule // tb
`default_nettype wire
